// file: hw/bsce_exec.sv
// Execution of returns, compares, skips, flag branches and I/O bit
// set/clear inside a small 8-bit core.
// Assumes the core presents one instruction at a time with its PC,
// register operands read combinationally from rd_sel and rr_sel, I/O
// read data for io_addr in the same cycle, and stack bytes on pop.
//
// Function
// [RULE1] Equal registers skip next instruction, flags kept.
// [RULE2] Compares subtract, update Z N V C H.
// [RULE3] Skip when register bit is zero.
// [RULE4] Skip when register bit is one.
// [RULE5] Skip when I/O register bit is zero.
// [RULE6] Skip when I/O register bit is one.
// [RULE7] Branch on set flag to PC+k+1.
// [RULE8] Branch on cleared flag, else sequential.
// [RULE9] Equal/not-equal on Z, minus/plus on N.
// [RULE10] Carry set/lower and clear/higher use C.
// [RULE11] Signed greater-or-equal when N xor V zero.
// [RULE12] Signed less-than when N xor V one.
// [RULE13] Half-carry branches test H.
// [RULE14] Transfer-flag branches test T.
// [RULE15] Overflow branches test V.
// [RULE16] Interrupt-enable branches test I.
// [RULE17] Set I/O bit, two cycles.
// [RULE18] Clear I/O bit, two cycles.
// [RULE19] Subroutine return pops PC, four cycles.
// [RULE20] Taken branch two cycles, skip adds one/two.
// [RULE21] Interrupt return pops PC, sets I.
`include "bsce_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bsce_exec #(
    parameter int PC_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [PC_W-1:0] pc_cur,
    input wire logic next_two_word,
    output logic exec_ready,
    output logic [4:0] rd_sel,
    output logic [4:0] rr_sel,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] rr_val,
    input wire logic [7:0] status_flags,
    output logic [7:0] flags_out,
    output logic flags_we,
    output logic [5:0] io_addr,
    input wire logic [7:0] io_rd_data,
    output logic [7:0] io_wr_data,
    output logic io_we,
    output logic stack_pop,
    input wire logic [7:0] stack_data,
    output logic [PC_W-1:0] pc_next,
    output logic done
);
    import bsce_pkg::*;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    logic [3:0] opcode;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [5:0] io_field;
    logic [PC_W-1:0] offset;
    logic take;

    assign opcode = instr[`BSCE_OP_HI:`BSCE_OP_LO];
    assign bit_sel = instr[`BSCE_BIT_HI:`BSCE_BIT_LO];
    assign imm = instr[`BSCE_IMM_HI:`BSCE_IMM_LO];
    assign io_field = instr[`BSCE_IO_HI:`BSCE_IO_LO];
    assign offset = PC_W'($signed(instr[`BSCE_OFS_HI:`BSCE_OFS_LO]));
    assign take = instr_valid && exec_ready;

    bsce_state_t state;
    logic [2:0] cnt;
    logic is_return;
    logic irq_ret;
    logic [5:0] io_hold;

    always_comb begin
        if (opcode == `BSCE_OP_CMP_IMM) begin
            rd_sel = {`BSCE_IMM_RD_BASE,
                      instr[`BSCE_IMM_RD_HI:`BSCE_IMM_RD_LO]};
        end else if (opcode == `BSCE_OP_SKIP_REG_CLR ||
                     opcode == `BSCE_OP_SKIP_REG_SET) begin
            rd_sel = instr[`BSCE_BREG_HI:`BSCE_BREG_LO];
        end else begin
            rd_sel = instr[`BSCE_RD_HI:`BSCE_RD_LO];
        end
    end
    assign rr_sel = instr[`BSCE_RR_HI:`BSCE_RR_LO];

    // The address is held while a write is pending, so the core need
    // not keep the instruction word stable after it was taken.
    assign io_addr = (state == BSCE_BUSY) ? io_hold : io_field;
    assign exec_ready = (state == BSCE_IDLE);
    // High byte is popped first, low byte second.
    assign stack_pop = (state == BSCE_BUSY) && is_return &&
                       (cnt == 3'd3 || cnt == 3'd2); // [RULE19]

    // ------------------------------------------------------------
    // Compare arithmetic
    // ------------------------------------------------------------
    logic [7:0] sub_b;
    logic carry_in;
    logic [7:0] diff;
    logic [7:0] cmp_flags;

    assign sub_b = (opcode == `BSCE_OP_CMP_IMM) ? imm : rr_val;
    assign carry_in = (opcode == `BSCE_OP_CMP_CARRY) &&
                      status_flags[`BSCE_FL_C];
    assign diff = 8'(rd_val - sub_b - {7'h00, carry_in}); // [RULE2]

    always_comb begin
        cmp_flags = status_flags;
        cmp_flags[`BSCE_FL_H] = (~rd_val[3] & sub_b[3]) |
                                (sub_b[3] & diff[3]) |
                                (diff[3] & ~rd_val[3]); // [RULE2]
        cmp_flags[`BSCE_FL_C] = (~rd_val[7] & sub_b[7]) |
                                (sub_b[7] & diff[7]) |
                                (diff[7] & ~rd_val[7]); // [RULE2]
        cmp_flags[`BSCE_FL_V] = (rd_val[7] & ~sub_b[7] & ~diff[7]) |
                                (~rd_val[7] & sub_b[7] & diff[7]);
        cmp_flags[`BSCE_FL_N] = diff[7];
        cmp_flags[`BSCE_FL_S] = diff[7] ^ cmp_flags[`BSCE_FL_V];
        // With carry in, zero can only survive a chain of zero bytes.
        if (opcode == `BSCE_OP_CMP_CARRY) begin
            cmp_flags[`BSCE_FL_Z] = (diff == 8'h00) &&
                                    status_flags[`BSCE_FL_Z];
        end else begin
            cmp_flags[`BSCE_FL_Z] = (diff == 8'h00); // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // Conditions and next program counter
    // ------------------------------------------------------------
    logic flag_bit;
    logic skip_cond;
    logic branch;
    logic [PC_W-1:0] pc_seq;
    logic [PC_W-1:0] pc_skip;

    bsce_flag_test u_flag_test (
        .flags(status_flags),
        .sel(bit_sel),
        .value(flag_bit)
    );

    assign pc_seq = PC_W'(pc_cur + 1'b1);
    // Skip length is fixed at take by the core's size decode.
    assign pc_skip = next_two_word ? PC_W'(pc_cur + 2'd3) :
                                     PC_W'(pc_cur + 2'd2); // [RULE20]

    always_comb begin
        skip_cond = 1'b0;
        branch = 1'b0;
        case (opcode)
            `BSCE_OP_CMP_SKIP_EQ: skip_cond = (rd_val == rr_val); // [RULE1]
            `BSCE_OP_SKIP_REG_CLR: skip_cond = ~rd_val[bit_sel]; // [RULE3]
            `BSCE_OP_SKIP_REG_SET: skip_cond = rd_val[bit_sel]; // [RULE4]
            `BSCE_OP_SKIP_IO_CLR: skip_cond = ~io_rd_data[bit_sel]; // [RULE5]
            `BSCE_OP_SKIP_IO_SET: skip_cond = io_rd_data[bit_sel]; // [RULE6]
            // Named branches are these two with a fixed flag select:
            // Z, N, C, S, H, T, V and I give the paired forms.
            `BSCE_OP_BR_SET: branch = flag_bit; // [RULE7] [RULE9] [RULE10]
            `BSCE_OP_BR_CLR: branch = ~flag_bit; // [RULE8] [RULE9] [RULE10]
            default: begin
                skip_cond = 1'b0;
                branch = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= BSCE_IDLE;
            cnt <= 3'd0;
            is_return <= 1'b0;
            irq_ret <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                BSCE_IDLE: begin
                    if (take) begin
                        is_return <= (opcode == `BSCE_OP_RETURN);
                        irq_ret <= (opcode == `BSCE_OP_RETURN) &&
                                   instr[`BSCE_RET_IRQ_BIT]; // [RULE21]
                        if (opcode == `BSCE_OP_RETURN) begin
                            cnt <= `BSCE_CYC_RETURN - 3'd1; // [RULE19]
                            state <= BSCE_BUSY;
                        end else if (opcode == `BSCE_OP_SET_IO ||
                                     opcode == `BSCE_OP_CLR_IO) begin
                            cnt <= `BSCE_CYC_IO_WR - 3'd1; // [RULE17] [RULE18]
                            state <= BSCE_BUSY;
                        end else if (branch) begin
                            cnt <= `BSCE_CYC_TAKEN - 3'd1; // [RULE20]
                            state <= BSCE_BUSY;
                        end else if (skip_cond) begin
                            cnt <= next_two_word ? 3'd2 : 3'd1; // [RULE20]
                            state <= BSCE_BUSY;
                        end else begin
                            done <= 1'b1;
                        end
                    end
                end
                BSCE_BUSY: begin
                    cnt <= cnt - 3'd1;
                    if (cnt == 3'd1) begin
                        done <= 1'b1;
                        state <= BSCE_IDLE;
                    end
                end
                default: state <= BSCE_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program counter result
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_next <= '0;
        end else if (take) begin
            if (branch) begin
                pc_next <= PC_W'(pc_cur + offset + 1'b1); // [RULE7] [RULE8]
            end else if (skip_cond) begin
                pc_next <= pc_skip; // [RULE1] [RULE3] [RULE4] [RULE5] [RULE6]
            end else begin
                pc_next <= pc_seq;
            end
        end else if (stack_pop) begin
            // Sixteen-bit return address built high byte first.
            if (cnt == 3'd3) begin
                pc_next <= PC_W'({stack_data, 8'h00}); // [RULE19]
            end else begin
                pc_next <= PC_W'({pc_next[15:8], stack_data}); // [RULE19]
            end
        end
    end

    // ------------------------------------------------------------
    // Status flag result
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_out <= 8'h00;
            flags_we <= 1'b0;
        end else begin
            flags_we <= 1'b0;
            if (take && (opcode == `BSCE_OP_CMP ||
                         opcode == `BSCE_OP_CMP_CARRY ||
                         opcode == `BSCE_OP_CMP_IMM)) begin
                flags_out <= cmp_flags; // [RULE2]
                flags_we <= 1'b1;
            end else if (take && opcode == `BSCE_OP_RETURN) begin
                flags_out <= status_flags;
                if (instr[`BSCE_RET_IRQ_BIT]) begin
                    flags_out[`BSCE_FL_I] <= 1'b1; // [RULE21]
                end
            end else if (irq_ret && state == BSCE_BUSY &&
                         cnt == 3'd1 && !status_flags[`BSCE_FL_I]) begin
                // Written on the last cycle only. A plain return never
                // writes, even when I falls while it runs, so it cannot
                // bring back a stale copy of the flags.
                flags_we <= 1'b1; // [RULE21]
            end
        end
    end

    // ------------------------------------------------------------
    // I/O bit write
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_hold <= 6'h00;
            io_wr_data <= 8'h00;
            io_we <= 1'b0;
        end else begin
            io_we <= 1'b0;
            if (take && (opcode == `BSCE_OP_SET_IO ||
                         opcode == `BSCE_OP_CLR_IO)) begin
                io_hold <= io_field;
                io_wr_data <= io_rd_data;
                // Read-modify-write: other bits keep the value read.
                io_wr_data[bit_sel] <=
                    (opcode == `BSCE_OP_SET_IO); // [RULE17] [RULE18]
                io_we <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// file: hw/bsce_map.svh
// Constants of the branch, skip and compare execution block.
// Assumes a 16-bit instruction word and an 8-bit status register.
`ifndef BSCE_MAP_SVH
`define BSCE_MAP_SVH

// ----------------------------------------------------------------
// Operation codes in instruction bits [15:12]
// ----------------------------------------------------------------
`define BSCE_OP_RETURN 4'h0
`define BSCE_OP_CMP_SKIP_EQ 4'h1
`define BSCE_OP_CMP 4'h2
`define BSCE_OP_CMP_CARRY 4'h3
`define BSCE_OP_CMP_IMM 4'h4
`define BSCE_OP_SKIP_REG_CLR 4'h5
`define BSCE_OP_SKIP_REG_SET 4'h6
`define BSCE_OP_SKIP_IO_CLR 4'h7
`define BSCE_OP_SKIP_IO_SET 4'h8
`define BSCE_OP_SET_IO 4'h9
`define BSCE_OP_CLR_IO 4'ha
`define BSCE_OP_BR_SET 4'hb
`define BSCE_OP_BR_CLR 4'hc
// Low bit of a return word selects the interrupt return.
`define BSCE_RET_IRQ_BIT 0

// ----------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------
`define BSCE_OP_HI 15
`define BSCE_OP_LO 12
`define BSCE_RD_HI 9
`define BSCE_RD_LO 5
`define BSCE_RR_HI 4
`define BSCE_RR_LO 0
`define BSCE_IMM_RD_HI 11
`define BSCE_IMM_RD_LO 8
`define BSCE_IMM_HI 7
`define BSCE_IMM_LO 0
`define BSCE_BREG_HI 7
`define BSCE_BREG_LO 3
`define BSCE_IO_HI 8
`define BSCE_IO_LO 3
`define BSCE_BIT_HI 2
`define BSCE_BIT_LO 0
`define BSCE_OFS_HI 9
`define BSCE_OFS_LO 3

// ----------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------
`define BSCE_FL_C 0
`define BSCE_FL_Z 1
`define BSCE_FL_N 2
`define BSCE_FL_V 3
`define BSCE_FL_S 4
`define BSCE_FL_H 5
`define BSCE_FL_T 6
`define BSCE_FL_I 7

// ----------------------------------------------------------------
// Cycle counts and the immediate-compare register base
// ----------------------------------------------------------------
`define BSCE_CYC_ONE 3'd1
`define BSCE_CYC_TAKEN 3'd2
`define BSCE_CYC_IO_WR 3'd2
`define BSCE_CYC_RETURN 3'd4
`define BSCE_IMM_RD_BASE 1'b1

`endif

// file: hw/bsce_pkg.sv
// Types of the branch, skip and compare execution block.
// Assumes the constants of bsce_map.svh are included where needed.
package bsce_pkg;

    typedef enum logic [1:0] {
        BSCE_IDLE = 2'b01,
        BSCE_BUSY = 2'b10
    } bsce_state_t;

endpackage

// file: hw/bsce_flag_test.sv
// Selects one status flag for a conditional branch.
// Assumes the flag layout of bsce_map.svh.
`include "bsce_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bsce_flag_test (
    input wire logic [7:0] flags,
    input wire logic [2:0] sel,
    output logic value
);
    import bsce_pkg::*;

    always_comb begin
        // The sign flag is rebuilt from N and V so signed tests stay
        // right even when the stored sign bit is stale.
        if (sel == 3'(`BSCE_FL_S)) begin
            value = flags[`BSCE_FL_N] ^ flags[`BSCE_FL_V]; // [RULE11] [RULE12]
        end else begin
            value = flags[sel]; // [RULE13] [RULE14] [RULE15] [RULE16]
        end
    end
endmodule

`default_nettype wire

// file: verif/bsce_exec_sva.sv
// Checker for the branch, skip and compare execution block.
// Assumes the design top bsce_exec and the constants of bsce_map.svh.
`include "bsce_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bsce_exec_chk #(
    parameter int PC_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [PC_W-1:0] pc_cur,
    input wire logic next_two_word,
    input wire logic exec_ready,
    input wire logic [4:0] rd_sel,
    input wire logic [4:0] rr_sel,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] rr_val,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] flags_out,
    input wire logic flags_we,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_rd_data,
    input wire logic [7:0] io_wr_data,
    input wire logic io_we,
    input wire logic stack_pop,
    input wire logic [7:0] stack_data,
    input wire logic [PC_W-1:0] pc_next,
    input wire logic done
);
    // ----------------------------------------------------------------
    // Helper terms
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic hit;
    logic [PC_W-1:0] pc1, pc2, pc3, tgt;
    assign take = instr_valid && exec_ready;
    assign pc1 = pc_cur + PC_W'(1);
    assign pc2 = pc_cur + PC_W'(2);
    assign pc3 = pc_cur + PC_W'(3);
    assign tgt = pc1 + PC_W'($signed(instr[9:3]));
    // Select 4 follows N xor V rather than the stored sign bit.
    assign hit = (instr[2:0] == 3'd4) ? (status_flags[2] ^ status_flags[3])
                                      : status_flags[instr[2:0]];

    sequence s_take(logic [3:0] o, logic c);
        take && instr[15:12] == o && c;
    endsequence
    sequence s_pops;
        stack_pop ##1 stack_pop;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_cmp_one_cycle: assert property (s_take(`BSCE_OP_CMP, 1'b1) |=>
        done && flags_we && pc_next == $past(pc1))
        else $error("compare did not finish in one cycle");
    a_cmp_zero_carry: assert property (s_take(`BSCE_OP_CMP, 1'b1)
        |=> flags_out[`BSCE_FL_Z] == ($past(rd_val) == $past(rr_val)) &&
        flags_out[`BSCE_FL_C] == ($past(rd_val) < $past(rr_val)))
        else $error("compare zero or carry flag wrong");
    a_compare_skip_equal_skip_one: assert property (s_take(`BSCE_OP_CMP_SKIP_EQ,
        rd_val == rr_val && !next_two_word) |=> !done && !flags_we
        ##1 done && !flags_we && pc_next == $past(pc2, 2))
        else $error("equal compare skip wrong");
    a_skip_io_two: assert property (s_take(`BSCE_OP_SKIP_IO_CLR,
        !io_rd_data[instr[2:0]] && next_two_word) |=> !done [*2]
        ##1 done && pc_next == $past(pc3, 3))
        else $error("io skip over two words wrong");
    a_br_set_taken: assert property (s_take(`BSCE_OP_BR_SET, hit)
        |=> !exec_ready ##1 done && pc_next == $past(tgt, 2))
        else $error("taken branch on set flag wrong");
    a_br_clr_taken: assert property (s_take(`BSCE_OP_BR_CLR, !hit)
        |=> !exec_ready ##1 done && pc_next == $past(tgt, 2))
        else $error("taken branch on clear flag wrong");
    a_br_fall_thru: assert property (s_take(`BSCE_OP_BR_SET, !hit)
        |=> done && exec_ready && pc_next == $past(pc1))
        else $error("untaken branch wrong");
    a_set_io_bit: assert property (s_take(`BSCE_OP_SET_IO, 1'b1)
        |=> io_we && io_wr_data == ($past(io_rd_data) |
        (8'h01 << $past(instr[2:0]))) ##1 done && !io_we && !flags_we)
        else $error("set io bit wrong");
    a_clr_io_bit: assert property (s_take(`BSCE_OP_CLR_IO, 1'b1)
        |=> io_we && io_wr_data == ($past(io_rd_data) &
        ~(8'h01 << $past(instr[2:0]))) ##1 done && !io_we && !flags_we)
        else $error("clear io bit wrong");
    a_ret_four_cyc: assert property (s_take(`BSCE_OP_RETURN, 1'b1)
        |=> s_pops ##1 !done ##1 done)
        else $error("return did not take four cycles");
    a_irq_ret_ie: assert property (s_take(`BSCE_OP_RETURN,
        instr[`BSCE_RET_IRQ_BIT]) ##3 !status_flags[`BSCE_FL_I] |=>
        flags_we && flags_out[`BSCE_FL_I])
        else $error("interrupt return left interrupts off");
endmodule

bind bsce_exec bsce_exec_chk #(.PC_W(PC_W)) chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .pc_cur(pc_cur), .next_two_word(next_two_word),
    .exec_ready(exec_ready), .rd_sel(rd_sel), .rr_sel(rr_sel),
    .rd_val(rd_val), .rr_val(rr_val), .status_flags(status_flags),
    .flags_out(flags_out), .flags_we(flags_we), .io_addr(io_addr),
    .io_rd_data(io_rd_data), .io_wr_data(io_wr_data), .io_we(io_we),
    .stack_pop(stack_pop), .stack_data(stack_data),
    .pc_next(pc_next), .done(done)
);
`default_nettype wire

// file: verif/branch_skip_compare_exec_tb.sv
// Self-checking bench for the branch, skip and compare execution block.
// Assumes bsce_exec with PC_W 16; the bench plays core and stack.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module branch_skip_compare_exec_tb;
    logic ref_clk, rst_n, instr_valid, next_two_word;
    logic [15:0] instr, pc_cur, pc_next;
    logic [7:0] rd_val, rr_val, status_flags, io_rd_data, stack_data;
    logic [7:0] flags_out, io_wr_data, fo, sd_hi, sd_lo;
    logic [4:0] rd_sel, rr_sel;
    logic [5:0] io_addr, ioa;
    logic exec_ready, flags_we, io_we, stack_pop, done;
    int error_cnt, tests_run, fw_n, io_n, pop_n;

    bsce_exec #(.PC_W(16)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .pc_cur(pc_cur), .next_two_word(next_two_word),
        .exec_ready(exec_ready), .rd_sel(rd_sel), .rr_sel(rr_sel),
        .rd_val(rd_val), .rr_val(rr_val), .status_flags(status_flags),
        .flags_out(flags_out), .flags_we(flags_we), .io_addr(io_addr),
        .io_rd_data(io_rd_data), .io_wr_data(io_wr_data), .io_we(io_we),
        .stack_pop(stack_pop), .stack_data(stack_data),
        .pc_next(pc_next), .done(done)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Issues one word, then counts cycles until done, feeding stack bytes.
    task automatic run(input logic [15:0] ins, input logic tw,
                       output int n);
        fw_n = 0;
        io_n = 0;
        pop_n = 0;
        @(negedge ref_clk);
        instr = ins;
        next_two_word = tw;
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
        instr = 16'hffff;
        next_two_word = ~tw;
        for (n = 1; n < 10; n++) begin
            stack_data = (n == 1) ? sd_hi : (n == 2) ? sd_lo : ~sd_lo;
            if (stack_pop) pop_n++;
            if (flags_we) begin
                fw_n++;
                fo = flags_out;
            end
            if (io_we) begin
                io_n++;
                ioa = io_addr;
            end
            if (done) break;
            @(negedge ref_clk);
        end
        if (n == 10) begin
            error_cnt++;
            $display("ERROR at %0t: no completion", $time);
            give_verdict();
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_cmp();
        int n;
        instr = 16'h2041;
        #1;
        `CHK(rd_sel, 5'h02)
        `CHK(rr_sel, 5'h01)
        rd_val = 8'h10;
        rr_val = 8'h20;
        status_flags = 8'h00;
        run(16'h2041, 1'b0, n);
        `CHK(n, 1)
        `CHK(fo & 8'h2f, 8'h05)
        `CHK(pc_next, 16'h0101)
        rd_val = 8'h05;
        rr_val = 8'h05;
        status_flags = 8'h01;
        run(16'h3041, 1'b0, n);
        `CHK(fo & 8'h2f, 8'h25)
        status_flags = 8'h00;
        instr = 16'h4305;
        #1;
        `CHK(rd_sel, 5'h13)
        run(16'h4305, 1'b0, n);
        `CHK(fw_n, 1)
        `CHK(fo & 8'h2f, 8'h02)
        $display("compare test finished");
    endtask

    task automatic t_compare_skip_equal();
        int n;
        rd_val = 8'h5a;
        rr_val = 8'h5a;
        run(16'h1041, 1'b1, n);
        `CHK(n, 3)
        `CHK(pc_next, 16'h0103)
        `CHK(fw_n, 0)
        run(16'h1041, 1'b0, n);
        `CHK(n, 2)
        `CHK(pc_next, 16'h0102)
        rr_val = 8'h5b;
        run(16'h1041, 1'b1, n);
        `CHK(n, 1)
        `CHK(pc_next, 16'h0101)
        $display("compare skip test finished");
    endtask

    task automatic t_skip();
        int n;
        logic sk;
        instr = 16'h5156;
        #1;
        `CHK(rd_sel, 5'h0a)
        for (int o = 5; o <= 8; o++) begin
            for (int b = 0; b < 4; b++) begin
                sk = o[0] ^ b[0];
                rd_val = b[0] ? 8'h40 : 8'hbf;
                rr_val = rd_val;
                io_rd_data = rd_val;
                run({o[3:0], 12'h156}, b[1], n);
                `CHK(n, sk ? 2 + b[1] : 1)
                `CHK(pc_next, sk ? 16'h0102 + b[1] : 16'h0101)
                `CHK(fw_n, 0)
            end
        end
        $display("skip test finished");
    endtask

    task automatic t_branch();
        int n;
        logic tk;
        logic [15:0] pc_exp;
        for (int o = 11; o <= 12; o++) begin
            for (int s = 0; s < 8; s++) begin
                for (int f = 0; f < 2; f++) begin
                    status_flags = f[0] ? ((8'h01 << s) |
                        ((s == 4) ? 8'h04 : 8'h00)) : ~(8'h01 << s);
                    tk = (o == 11) == f[0];
                    run({o[3:0], 2'b00, s[0] ? 7'h3f : 7'h40, s[2:0]},
                        1'b0, n);
                    pc_exp = tk ? (s[0] ? 16'h0140 : 16'h00c1) : 16'h0101;
                    `CHK(n, tk ? 2 : 1)
                    `CHK(pc_next, pc_exp)
                    `CHK(fw_n, 0)
                end
            end
        end
        $display("branch test finished");
    endtask

    task automatic t_io();
        int n;
        io_rd_data = 8'h81;
        run(16'h9156, 1'b0, n);
        `CHK(n, 2)
        `CHK(io_n, 1)
        `CHK(ioa, 6'h2a)
        `CHK(io_wr_data, 8'hc1)
        io_rd_data = 8'hff;
        run(16'ha156, 1'b0, n);
        `CHK(n, 2)
        `CHK(io_wr_data, 8'hbf)
        `CHK(fw_n, 0)
        $display("io bit test finished");
    endtask

    task automatic t_ret();
        int n;
        status_flags = 8'h00;
        sd_hi = 8'h12;
        sd_lo = 8'h34;
        run(16'h0000, 1'b0, n);
        `CHK(n, 4)
        `CHK(pop_n, 2)
        `CHK(pc_next, 16'h1234)
        `CHK(fw_n, 0)
        sd_hi = 8'hab;
        sd_lo = 8'hcd;
        run(16'h0001, 1'b0, n);
        `CHK(n, 4)
        `CHK(pc_next, 16'habcd)
        `CHK(fw_n, 1)
        `CHK(fo[7], 1'b1)
        $display("return test finished");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, instr_valid, next_two_word} = 3'b000;
        {instr, rd_val, rr_val, status_flags} = 40'h0;
        {io_rd_data, stack_data, sd_hi, sd_lo} = 32'h0;
        pc_cur = 16'h0100;
        error_cnt = 0;
        tests_run = 0;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        `CHK(exec_ready, 1'b1)
        `CHK(pc_next, 16'h0000)
        `CHK(done, 1'b0)
        t_cmp();
        t_compare_skip_equal();
        t_skip();
        t_branch();
        t_io();
        t_ret();
        give_verdict();
    end
endmodule
`default_nettype wire
